// ### acsp_pkg.sv
`default_nettype none
package acsp_pkg;
  // Result word
  localparam int unsigned RESULT_W   = 14;
  localparam int unsigned CFG_W      = 9;
  // Configuration field positions
  localparam int unsigned CFG_START  = 8;
  localparam int unsigned CFG_RANGE7 = 7;
  localparam int unsigned CFG_RANGE6 = 6;
  localparam int unsigned CFG_PD     = 5;
  localparam int unsigned CFG_PSCALE = 4;
  localparam int unsigned CFG_FAST   = 3;
  localparam int unsigned CFG_CODING = 2;
  localparam logic [8:0]  CFG_RESET  = 9'h000;
  // Writable field mask: bits 1:0 stay untouched by a port update
  localparam logic [8:0]  CFG_WMASK  = 9'h1fc;
  localparam logic [3:0]  BIT_CNT_MAX = 4'hd;
  localparam logic [3:0]  CFG_CNT_LAST = 4'h8;

  typedef enum logic [1:0] {ACSP_RANGE_0_5, ACSP_RANGE_0_10, ACSP_RANGE_PM5, ACSP_RANGE_PM10} acsp_range_t;
  typedef enum logic [1:0] {ACSP_MODE_NORMAL, ACSP_MODE_FAST, ACSP_MODE_PSCALE, ACSP_MODE_RSVD} acsp_mode_t;

  typedef struct packed {
    acsp_range_t range;
    acsp_mode_t  mode;
    logic        power_down;
    logic        straight_binary;
  } acsp_cfg_t;
endpackage
`default_nettype wire

// ### acsp_core.sv
// Functional notes
// - Read-after read only when idle, selected
// - Result MSB first, fourteen bit clocks
// - Chain input sampled on opposite edge
// - During conversion, shift previous result out
// - Incomplete read at conversion end pulses overrun
// - Hardware pins may change any time
// - Software mode ignores hardware pins
// - Config port needs serial and software select
// - Port select low, polarity picks edge
// - Config shifted MSB first, start bit 8
// - Ninth config edge updates register
// - Reserved bits 1:0 never written
// - Config port works only in serial software mode
// - Reset clears configuration to zero
// - Bits 7:6 select input range
// - Bits 4:3 select conversion mode
// - Power-down bit keeps port usable
// - Coding bit: low twos, high binary
`default_nettype none
module acsp_core (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  // Converter core side
  input  wire logic                  i_busy,
  input  wire logic                  i_result_valid,
  input  wire logic [13:0]           i_result,
  // Result readout pins
  input  wire logic                  i_chip_select_n,
  input  wire logic                  i_read_enable_n,
  input  wire logic                  i_serial_bit_clock,
  input  wire logic                  i_chain_serial_in,
  input  wire logic                  i_clock_polarity_invert,
  output logic                       o_serial_result_out,
  output logic                       o_serial_result_oe,
  output logic                       o_read_overrun_flag,
  // Mode selects
  input  wire logic                  i_serial_parallel_select,
  input  wire logic                  i_hardware_software_config_select,
  // Hardware configuration pins
  input  wire logic [1:0]            i_hw_range,
  input  wire logic                  i_hw_power_scaled,
  input  wire logic                  i_hw_fast,
  input  wire logic                  i_hw_power_down,
  input  wire logic                  i_output_coding_select,
  // Configuration write port
  input  wire logic                  i_config_port_select_n,
  input  wire logic                  i_config_serial_clock,
  input  wire logic                  i_config_serial_data_in,
  // Effective settings
  output acsp_pkg::acsp_cfg_t        o_cfg,
  output logic [8:0]                 o_cfg_reg,
  // Result buffer drain
  output logic                       o_word_valid,
  input  wire logic                  i_word_ready,
  output logic [13:0]                o_word
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NSYNC = 9;
  // Active-low selects come out of reset at their idle high level, so no false select follows reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 9'h10c;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] sync3_reg;
  assign raw_in = {i_config_port_select_n, i_config_serial_clock, i_config_serial_data_in,
                   i_serial_parallel_select, i_hardware_software_config_select,
                   i_chip_select_n, i_read_enable_n, i_serial_bit_clock, i_chain_serial_in};
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
      sync3_reg <= SYNC_IDLE;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  wire cps_n   = sync2_reg[8];
  wire ccl     = sync2_reg[7];
  wire ccl_d   = sync3_reg[7];
  wire cdin    = sync2_reg[6];
  wire ser_sel = sync2_reg[5];
  wire hw_sel  = sync2_reg[4];
  wire cs_n    = sync2_reg[3];
  wire rd_n    = sync2_reg[2];
  wire sck     = sync2_reg[1];
  wire sck_d   = sync3_reg[1];
  wire chain   = sync2_reg[0];

  // Polarity invert is a static strap, treated as quasi-static
  wire inv = i_clock_polarity_invert;
  wire sck_rise  = sck & ~sck_d;
  wire sck_fall  = ~sck & sck_d;
  wire shift_edg = inv ? sck_fall : sck_rise;
  wire samp_edg  = inv ? sck_rise : sck_fall;
  wire ccl_edge  = inv ? (~ccl & ccl_d) : (ccl & ~ccl_d);

  // ----------------------------------------------------------------
  // Two-entry result buffer
  // ----------------------------------------------------------------
  // A stalled drain drops a third word; i_result_valid is ignored while both entries are full.
  logic [13:0] buf_reg [2];
  logic [1:0]  cnt_reg;
  logic        rd_ptr_reg;
  logic        wr_ptr_reg;
  wire  buf_in_ready = (cnt_reg != 2'h2);
  wire  buf_push     = i_result_valid & buf_in_ready;
  wire  buf_pop      = o_word_valid & i_word_ready;
  assign o_word_valid = (cnt_reg != 2'h0);
  assign o_word       = buf_reg[rd_ptr_reg];
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_reg    <= 2'h0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
    end else begin
      if (buf_push) begin
        buf_reg[wr_ptr_reg] <= i_result;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (buf_pop) rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // ----------------------------------------------------------------
  // Result shifter
  // ----------------------------------------------------------------
  logic [13:0] shift_reg;
  logic [3:0]  bits_reg;
  logic        done_reg;
  logic        busy_d_reg;
  logic        ovr_reg;
  logic        chain_bit_reg;
  wire  sel          = ~cs_n & ~rd_n;
  // Next word loads while deselected, unless a read of the previous one stands part-way.
  wire  load_word    = o_word_valid & (done_reg | ~sel) & ~(|bits_reg);
  wire  conv_end     = busy_d_reg & ~i_busy;
  wire  read_pending = ~done_reg & (|bits_reg);
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      shift_reg     <= '0;
      bits_reg      <= 4'h0;
      done_reg      <= 1'b1;
      busy_d_reg    <= 1'b0;
      ovr_reg       <= 1'b0;
      chain_bit_reg <= 1'b0;
    end else begin
      busy_d_reg <= i_busy;
      ovr_reg    <= conv_end & read_pending;
      // Before the first shift the upstream MSB already stands on the chain input
      if (sel && (samp_edg || (!done_reg && bits_reg == 4'h0))) chain_bit_reg <= chain;
      if (load_word && !sel) begin
        shift_reg <= o_word;
        done_reg  <= 1'b0;
      end else if (sel && shift_edg) begin
        // MSB leaves first; chain bits enter behind the own word
        shift_reg <= {shift_reg[12:0], chain_bit_reg};
        if (bits_reg == acsp_pkg::BIT_CNT_MAX) begin
          bits_reg <= 4'h0;
          done_reg <= 1'b1;
        end else if (!done_reg) begin
          bits_reg <= bits_reg + 4'h1;
        end
      end
    end
  end
  // Overrun applies only to a word that was being read when busy fell
  assign o_serial_result_out = shift_reg[13];
  assign o_serial_result_oe  = sel & ser_sel;
  assign o_read_overrun_flag = ovr_reg;

  // ----------------------------------------------------------------
  // Configuration write port
  // ----------------------------------------------------------------
  logic [8:0] cfg_sh_reg;
  logic [3:0] cfg_cnt_reg;
  logic [8:0] cfg_reg;
  wire  port_en = ser_sel & ~hw_sel;
  wire  cfg_act = port_en & ~cps_n;
  wire  [8:0] cfg_word = {cfg_sh_reg[7:0], cdin};
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cfg_sh_reg  <= '0;
      cfg_cnt_reg <= 4'h0;
      cfg_reg     <= acsp_pkg::CFG_RESET;
    end else if (!cfg_act) begin
      cfg_cnt_reg <= 4'h0;
    end else if (ccl_edge) begin
      cfg_sh_reg <= cfg_word;
      if (cfg_cnt_reg == acsp_pkg::CFG_CNT_LAST) begin
        cfg_cnt_reg <= 4'h0;
        // Reserved bits keep their value; power-down leaves the port alive
        cfg_reg <= (cfg_word & acsp_pkg::CFG_WMASK) |
                   (cfg_reg & ~acsp_pkg::CFG_WMASK);
      end else begin
        cfg_cnt_reg <= cfg_cnt_reg + 4'h1;
      end
    end
  end
  assign o_cfg_reg = cfg_reg;

  // ----------------------------------------------------------------
  // Effective settings
  // ----------------------------------------------------------------
  // Hardware pins are taken live; the core owns the acquisition settle time.
  wire sw_mode = ser_sel & ~hw_sel;
  wire [1:0] rng_bits = sw_mode ? {cfg_reg[acsp_pkg::CFG_RANGE7], cfg_reg[acsp_pkg::CFG_RANGE6]}
                                : i_hw_range;
  wire [1:0] mode_bits = sw_mode ? {cfg_reg[acsp_pkg::CFG_PSCALE], cfg_reg[acsp_pkg::CFG_FAST]}
                                 : {i_hw_power_scaled, i_hw_fast};
  wire pd_bit  = sw_mode ? cfg_reg[acsp_pkg::CFG_PD] : i_hw_power_down;
  wire ob_bit  = sw_mode ? cfg_reg[acsp_pkg::CFG_CODING] : i_output_coding_select;
  assign o_cfg.range = acsp_pkg::acsp_range_t'({rng_bits[0] & ~rng_bits[1] ? 2'h1 :
                                               rng_bits == 2'h2 ? 2'h2 : rng_bits});
  assign o_cfg.mode  = acsp_pkg::acsp_mode_t'(mode_bits == 2'h1 ? 2'h1 :
                                              mode_bits == 2'h2 ? 2'h2 : mode_bits);
  assign o_cfg.power_down      = pd_bit;
  assign o_cfg.straight_binary = ob_bit;

endmodule // acsp_core
`default_nettype wire

// ### acsp_core_asserts.sv
`default_nettype none
module acsp_core_chk (
  // Clock and reset
  input wire logic                i_clk,
  input wire logic                i_nrst,
  // Inputs
  input wire logic                i_busy,
  input wire logic                i_chip_select_n,
  input wire logic                i_serial_bit_clock,
  input wire logic                i_serial_parallel_select,
  input wire logic                i_hardware_software_config_select,
  // Outputs
  input wire logic                o_serial_result_out,
  input wire logic                o_serial_result_oe,
  input wire logic                o_read_overrun_flag,
  input wire acsp_pkg::acsp_cfg_t o_cfg,
  input wire logic [8:0]          o_cfg_reg
);
  // ----
  // Properties
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic sw_mode;
  assign sw_mode = i_serial_parallel_select && !i_hardware_software_config_select;
  a_reset_clears_cfg: assert property (disable iff (1'h0) !i_nrst |=> o_cfg_reg == 9'h000)
    else $error("config register not cleared by reset");
  a_reserved_bits_kept: assert property ($changed(o_cfg_reg) |-> o_cfg_reg[1:0] == $past(o_cfg_reg[1:0]))
    else $error("reserved config bits changed");
  // Six cycles covers the select synchronisers plus an edge already in flight
  a_port_refused: assert property ((!sw_mode)[*6] |=> $stable(o_cfg_reg))
    else $error("config register written outside software mode");
  a_sw_uses_reg: assert property (sw_mode[*4] |-> o_cfg == {o_cfg_reg[7:6], o_cfg_reg[4:3], o_cfg_reg[5], o_cfg_reg[2]})
    else $error("settings do not follow config register");
  a_overrun_pulse: assert property (o_read_overrun_flag |=> !o_read_overrun_flag)
    else $error("overrun flag longer than one cycle");
  a_overrun_cause: assert property ($rose(o_read_overrun_flag) |-> !i_busy)
    else $error("overrun flag while still converting");
  a_oe_deselect: assert property (i_chip_select_n[*4] |-> !o_serial_result_oe)
    else $error("result output driven while deselected");
  a_out_quiet: assert property ((!i_chip_select_n && $stable(i_serial_bit_clock))[*6] |-> $stable(o_serial_result_out))
    else $error("result output moved without a bit clock edge");
  c_overrun: cover property ($rose(o_read_overrun_flag));
  c_cfg_update: cover property ($changed(o_cfg_reg));
  c_selected: cover property ($rose(o_serial_result_oe));
endmodule // acsp_core_chk
bind acsp_core acsp_core_chk u_chk (.*);
`default_nettype wire

// ### acsp_host.sv
`default_nettype none
module acsp_host (
  // Result side
  input  wire logic i_out,
  output logic      o_sclk,
  output logic      o_chain,
  // Config port
  output logic      o_csel_n,
  output logic      o_cclk,
  output logic      o_cdin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Host serial controller, 160 ns bit period, idle low
  // ----
  initial begin
    o_sclk = 1'h0;
    o_chain = 1'h0;
    o_csel_n = 1'h1;
    o_cclk = 1'h0;
    o_cdin = 1'h1;
  end
  // Upstream shifts on the same rise, so its next bit settles before the falling edge
  task automatic rd(input int n, input logic [27:0] ch, output logic [27:0] q);
    q = '0;
    o_chain = ch[27];
    #7;
    for (int i = 0; i < n; i++) begin
      #80 q = {q[26:0], i_out};
      o_sclk = 1'h1;
      #40 o_chain = (i < 27) ? ch[26 - i] : 1'h0;
      #40 o_sclk = 1'h0;
    end
  endtask
  task automatic wr(input logic [8:0] d);
    #7 o_csel_n = 1'h0;
    for (int i = 8; i >= 0; i--) begin
      #40 o_cdin = d[i];
      #40 o_cclk = 1'h1;
      #80 o_cclk = 1'h0;
    end
    #80 o_csel_n = 1'h1;
    o_cdin = ~o_cdin;
  endtask
endmodule // acsp_host
`default_nettype wire

// ### tb_adc_slave_serial_and_config_port.sv
`default_nettype none
module tb_adc_slave_serial_and_config_port;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Signals and helpers
  // ----
  logic i_clk = 1'h0, i_nrst = 1'h0, i_busy = 1'h0, i_result_valid = 1'h0, i_word_ready = 1'h1;
  logic i_chip_select_n = 1'h1, i_read_enable_n = 1'h1, i_clock_polarity_invert = 1'h0;
  logic i_serial_parallel_select = 1'h1, i_hardware_software_config_select = 1'h0;
  logic i_hw_power_scaled = 1'h1, i_hw_fast = 1'h0, i_hw_power_down = 1'h0, i_output_coding_select = 1'h0;
  logic [1:0] i_hw_range = 2'h0;
  logic [13:0] i_result = 14'h0000;
  logic i_serial_bit_clock, i_chain_serial_in, i_config_port_select_n, i_config_serial_clock;
  logic i_config_serial_data_in, o_serial_result_out, o_serial_result_oe, o_read_overrun_flag, o_word_valid;
  logic [13:0] o_word;
  logic [8:0] o_cfg_reg;
  acsp_pkg::acsp_cfg_t o_cfg;
  logic [27:0] q;
  int fails = 0, total_checks = 0;
  acsp_host host (
    .i_out    (o_serial_result_out),
    .o_sclk   (i_serial_bit_clock),
    .o_chain  (i_chain_serial_in),
    .o_csel_n (i_config_port_select_n),
    .o_cclk   (i_config_serial_clock),
    .o_cdin   (i_config_serial_data_in)
  );
  acsp_core dut (.*);
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  task automatic chk(string n, logic [27:0] s, logic [27:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic push(logic [13:0] w);
    @(negedge i_clk);
    i_result_valid = 1'h1;
    i_result = w;
    @(negedge i_clk);
    i_result_valid = 1'h0;
  endtask
  task automatic sel_rd(int n, logic [27:0] ch);
    i_chip_select_n = 1'h0;
    i_read_enable_n = 1'h0;
    repeat (4) @(negedge i_clk);
    host.rd(n, ch, q);
    @(negedge i_clk);
  endtask
  task automatic desel;
    repeat (8) @(negedge i_clk);
    i_chip_select_n = 1'h1;
    i_read_enable_n = 1'h1;
    repeat (4) @(negedge i_clk);
  endtask
  // Busy high across the read; it falls after n bits, short reads must flag
  task automatic t_busy(int n, logic [13:0] w, int e);
    int c;
    c = 0;
    @(negedge i_clk);
    i_busy = 1'h1;
    push(w);
    sel_rd(n, '0);
    i_busy = 1'h0;
    repeat (10) begin
      @(negedge i_clk);
      if (o_read_overrun_flag === 1'h1) c++;
    end
    chk("overrun", c, e);
    chk("busy_bits", q, w >> (14 - n));
    desel();
  endtask
  task automatic t_cfg(logic hw, logic [8:0] d, logic [8:0] er, logic [5:0] ec);
    @(negedge i_clk);
    i_hardware_software_config_select = hw;
    repeat (6) @(negedge i_clk);
    host.wr(d);
    repeat (6) @(negedge i_clk);
    chk("cfg_reg", o_cfg_reg, er);
    chk("cfg", o_cfg, ec);
  endtask
  task automatic end_of_test;
    $display("total_checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (3) @(negedge i_clk);
    i_nrst = 1'h1;
    repeat (4) @(negedge i_clk);
    push(14'h2a5c);
    sel_rd(14, '0);
    chk("word", q, 14'h2a5c);
    desel();
    push(14'h13c7);
    sel_rd(28, {14'h0ac5, 14'h0000});
    chk("chain", q, {14'h13c7, 14'h0ac5});
    desel();
    t_busy(14, 14'h1e01, 0);
    t_busy(5, 14'h0f0f, 1);
    t_cfg(1'h0, 9'h1ff, 9'h1fc, 6'h3f);
    t_cfg(1'h0, 9'h1b4, 9'h1b4, 6'h2b);
    t_cfg(1'h0, 9'h14c, 9'h14c, 6'h15);
    t_cfg(1'h1, 9'h1ff, 9'h14c, 6'h08);
    t_cfg(1'h0, 9'h0ff, 9'h0fc, 6'h3f);
    i_nrst = 1'h0;
    repeat (4) @(negedge i_clk);
    i_nrst = 1'h1;
    // Mode selects need the synchroniser depth before the settings follow them
    repeat (3) @(negedge i_clk);
    chk("cfg_reg", o_cfg_reg, 9'h000);
    chk("cfg", o_cfg, 6'h00);
    i_word_ready = 1'h0;
    push(14'h0123);
    push(14'h3210);
    chk("word_valid", o_word_valid, 1'h1);
    chk("buf_word", o_word, 14'h0123);
    i_word_ready = 1'h1;
    @(negedge i_clk);
    chk("buf_word", o_word, 14'h3210);
    @(negedge i_clk);
    chk("word_valid", o_word_valid, 1'h0);
    end_of_test();
  end
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
endmodule // tb_adc_slave_serial_and_config_port
`default_nettype wire
